// File: atl_pkg.sv
// Purpose: shared constants and types for the transmit/label controller
// Assumes: 50 MHz system clock, 1 MHz data-clock enable derived here
// Notes: register map is byte addressed, one 32-bit word per register
package atl_pkg;
    // data clock enable
    localparam int CLK_HZ = 50_000_000;
    localparam int DATA_CLK_HZ = 1_000_000;
    localparam int TICK_DIV = CLK_HZ / DATA_CLK_HZ;
    // first-bit bound, 2.5 data clocks
    localparam int FIRST_BIT_NS = 2500;
    localparam int FIRST_BIT_CYC = FIRST_BIT_NS / (1_000_000_000 / CLK_HZ);
    // bit timing in data clocks
    localparam logic [8:0] HS_HALF = 9'h005;
    localparam logic [8:0] LS_HALF = 9'h028;
    localparam logic [8:0] HS_GAP = 9'h028;
    localparam logic [8:0] LS_GAP = 9'h140;
    localparam logic [4:0] LAST_BIT = 5'h1f;
    // fifo and label sizes
    localparam logic [5:0] FIFO_DEPTH = 6'h20;
    localparam logic [5:0] FIFO_HALF = 6'h10;
    localparam logic [4:0] LABEL_COUNT = 5'h10;
    // register byte offsets
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] TXLO_ADDR = 8'h04;
    localparam logic [7:0] TXHI_ADDR = 8'h08;
    localparam logic [7:0] STATUS_ADDR = 8'h0c;
    localparam logic [7:0] RX1LO_ADDR = 8'h10;
    localparam logic [7:0] RX1HI_ADDR = 8'h14;
    localparam logic [7:0] RX2LO_ADDR = 8'h18;
    localparam logic [7:0] RX2HI_ADDR = 8'h1c;
    localparam logic [7:0] CLEAR_ADDR = 8'h20;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // control register layout, bit 0 last
    typedef struct packed {
        logic repeater_on;
        logic tx_low_speed;
        logic bit_order_swap;
        logic parity_sense;
        logic external_path_select;
        logic [1:0] label_filter_on;
        logic parity_insert;
        logic label_access_mode;
    } atl_ctrl_t;
    localparam logic [8:0] CTRL_RESET = 9'h012;
    // status register layout
    typedef struct packed {
        logic [5:0] rx2_count;
        logic [5:0] rx1_count;
        logic [5:0] tx_count;
        logic tx_busy;
        logic tx_ready;
        logic tx_half;
        logic tx_full;
    } atl_status_t;
endpackage

// File: atl_tx_label_control.sv
// Purpose: transmitter, label memory and receive fifos behind AXI4-Lite
// Assumes: synchronous inputs, receivers deliver whole words
// Notes: one clock; serial timing runs from a 1 MHz enable
`timescale 1ns/1ps
module atl_tx_label_control
    import atl_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic transmit_go,
    input wire logic [1:0][31:0] rx_word,
    input wire logic [1:0] rx_valid,
    output logic serial_line_out_a,
    output logic serial_line_out_b,
    output logic tx_full_flag,
    output logic tx_half_flag,
    output logic tx_ready
);
    typedef enum logic [4:0] {
        S_IDLE = 5'b00001,
        S_LOAD = 5'b00010,
        S_DATA = 5'b00100,
        S_NULL = 5'b01000,
        S_GAP = 5'b10000
    } atl_state_t;

    atl_ctrl_t ctrl, next_ctrl;
    atl_state_t state;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic aw_held, w_held, wr_fire, rd_fire, clr;
    logic [5:0] tick_cnt;
    logic tick;
    logic [31:0] tx_mem [32];
    logic [4:0] tx_wp, tx_rp;
    logic [5:0] tx_cnt;
    logic [15:0] tx_low;
    logic ld1, ld2, tx_pop;
    logic [15:0] ld_data, rd_half;
    logic [31:0] tx_shift, lb_word;
    logic lb_valid;
    logic [4:0] bitn;
    logic [8:0] ph, half_len, gap_len;
    logic lam_rise;
    logic [1:0] in_valid, match, push, pop, rd_lo, rd_hi, lab_we, lab_rd;
    logic [1:0][31:0] in_word, head;
    logic [1:0][7:0] lab_q;
    logic [1:0][5:0] rx_cnt;
    atl_status_t status;

    // write address and data may come in either order
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    always_ff @(posedge clk) begin
        if (reset) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr == CTRL_ADDR ||
                    aw_addr == TXLO_ADDR || aw_addr == TXHI_ADDR ||
                    aw_addr == CLEAR_ADDR) ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // control register with byte enables, untouched by chip clear
    always_comb begin
        next_ctrl = ctrl;
        if (w_strb[0])
            next_ctrl[7:0] = w_data[7:0];
        if (w_strb[1])
            next_ctrl[8] = w_data[8];
    end
    assign lam_rise = wr_fire && aw_addr == CTRL_ADDR &&
        !ctrl.label_access_mode && next_ctrl.label_access_mode;
    always_ff @(posedge clk) begin
        if (reset)
            ctrl <= CTRL_RESET;
        else if (wr_fire && aw_addr == CTRL_ADDR)
            ctrl <= next_ctrl;
    end

    // write strobes: label stores in label mode, word loads otherwise
    assign clr = wr_fire && aw_addr == CLEAR_ADDR;
    assign lab_we[0] = wr_fire && aw_addr == TXLO_ADDR &&
        ctrl.label_access_mode;
    assign lab_we[1] = wr_fire && aw_addr == TXHI_ADDR &&
        ctrl.label_access_mode;
    assign ld1 = (wr_fire && aw_addr == TXLO_ADDR &&
        !ctrl.label_access_mode) || (ctrl.repeater_on && |rd_lo);
    assign ld2 = (wr_fire && aw_addr == TXHI_ADDR &&
        !ctrl.label_access_mode) || (ctrl.repeater_on && |rd_hi);
    assign ld_data = wr_fire ? w_data[15:0] : rd_half;

    // read side: labels on the high select in label mode
    always_comb begin
        rd_half = 16'h0000;
        case (s_axi_araddr)
            RX1LO_ADDR: rd_half = head[0][15:0];
            RX1HI_ADDR: rd_half = head[0][31:16];
            RX2LO_ADDR: rd_half = head[1][15:0];
            RX2HI_ADDR: rd_half = head[1][31:16];
            default: rd_half = 16'h0000;
        endcase
    end
    assign status = '{rx2_count: rx_cnt[1], rx1_count: rx_cnt[0],
        tx_count: tx_cnt, tx_busy: state != S_IDLE, tx_ready: tx_ready,
        tx_half: tx_half_flag, tx_full: tx_full_flag};
    always_ff @(posedge clk) begin
        if (reset) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
            case (s_axi_araddr)
                CTRL_ADDR: s_axi_rdata <= {23'h00_0000, ctrl};
                STATUS_ADDR: s_axi_rdata <= {10'h000, status};
                RX1LO_ADDR, RX2LO_ADDR: s_axi_rdata <= {16'h0000, rd_half};
                RX1HI_ADDR: s_axi_rdata <= ctrl.label_access_mode ?
                    {24'h00_0000, lab_q[0]} : {16'h0000, rd_half};
                RX2HI_ADDR: s_axi_rdata <= ctrl.label_access_mode ?
                    {24'h00_0000, lab_q[1]} : {16'h0000, rd_half};
                default: s_axi_rresp <= RESP_SLVERR;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // receivers: label match, suspension, fifo with overwrite
    for (genvar g = 0; g < 2; g++) begin : rx
        logic [31:0] mem [32];
        logic [7:0] lab [16];
        logic [4:0] wp, rp, wc, rc;
        logic [5:0] cnt;
        logic got_lo, got_hi, m, grow;
        logic [7:0] lo_a, hi_a;
        assign lo_a = g ? RX2LO_ADDR : RX1LO_ADDR;
        assign hi_a = g ? RX2HI_ADDR : RX1HI_ADDR;
        assign in_valid[g] = ctrl.external_path_select ? rx_valid[g] :
            lb_valid;
        assign in_word[g] = ctrl.external_path_select ? rx_word[g] :
            (g ? ~lb_word : lb_word);
        // all sixteen entries compared, zero included
        always_comb begin
            m = 1'b0;
            for (int i = 0; i < 16; i++)
                if (lab[i] == in_word[g][7:0])
                    m = 1'b1;
        end
        assign match[g] = m;
        assign push[g] = in_valid[g] && !ctrl.label_access_mode &&
            (!ctrl.label_filter_on[g] || m);
        assign rd_lo[g] = rd_fire && s_axi_araddr == lo_a &&
            !ctrl.label_access_mode && cnt != 6'h00;
        assign rd_hi[g] = rd_fire && s_axi_araddr == hi_a &&
            !ctrl.label_access_mode && cnt != 6'h00;
        assign pop[g] = (rd_lo[g] && got_hi) || (rd_hi[g] && got_lo);
        assign grow = push[g] && !(cnt == FIFO_DEPTH && !pop[g]);
        assign lab_rd[g] = rd_fire && s_axi_araddr == hi_a &&
            ctrl.label_access_mode;
        assign head[g] = mem[rp];
        assign rx_cnt[g] = cnt;
        assign lab_q[g] = (rc < LABEL_COUNT) ? lab[rc[3:0]] : 8'h00;
        // fifo pointers; 16-bit word halves tracked for pop
        always_ff @(posedge clk) begin
            if (reset || clr) begin
                wp <= 5'h00;
                rp <= 5'h00;
                cnt <= 6'h00;
                got_lo <= 1'b0;
                got_hi <= 1'b0;
            end else begin
                if (push[g] && !grow)
                    mem[wp - 5'h01] <= in_word[g];
                else if (grow) begin
                    mem[wp] <= in_word[g];
                    wp <= wp + 5'h01;
                end
                if (pop[g])
                    rp <= rp + 5'h01;
                if (grow && !pop[g])
                    cnt <= cnt + 6'h01;
                else if (pop[g] && !grow)
                    cnt <= cnt - 6'h01;
                if (pop[g]) begin
                    got_lo <= 1'b0;
                    got_hi <= 1'b0;
                end else begin
                    got_lo <= got_lo | rd_lo[g];
                    got_hi <= got_hi | rd_hi[g];
                end
            end
        end
        // label memory sequence counters restart on mode rise
        always_ff @(posedge clk) begin
            if (reset || lam_rise) begin
                wc <= 5'h00;
                rc <= 5'h00;
            end else begin
                if (lab_we[g] && wc < LABEL_COUNT) begin
                    lab[wc[3:0]] <= w_data[7:0];
                    wc <= wc + 5'h01;
                end
                if (lab_rd[g] && rc < LABEL_COUNT)
                    rc <= rc + 5'h01;
            end
        end
    end

    // data clock enable
    always_ff @(posedge clk) begin
        if (reset || tick) begin
            tick_cnt <= 6'h00;
        end else begin
            tick_cnt <= tick_cnt + 6'h01;
        end
    end
    assign tick = tick_cnt == 6'(TICK_DIV - 1);

    // transmit fifo; parity slot cleared when parity is inserted
    assign tx_pop = state == S_LOAD && tick;
    always_ff @(posedge clk) begin
        if (reset || clr) begin
            tx_wp <= 5'h00;
            tx_rp <= 5'h00;
            tx_cnt <= 6'h00;
            tx_low <= 16'h0000;
        end else begin
            if (ld1)
                tx_low <= ld_data;
            if (ld2 && tx_cnt != FIFO_DEPTH) begin
                tx_mem[tx_wp] <= {ctrl.parity_insert ? 1'b0 : ld_data[15],
                    ld_data[14:0], tx_low};
                tx_wp <= tx_wp + 5'h01;
            end
            if (tx_pop)
                tx_rp <= tx_rp + 5'h01;
            if (ld2 && tx_cnt != FIFO_DEPTH && !tx_pop)
                tx_cnt <= tx_cnt + 6'h01;
            else if (tx_pop && !(ld2 && tx_cnt != FIFO_DEPTH))
                tx_cnt <= tx_cnt - 6'h01;
        end
    end

    // fifo flags
    always_ff @(posedge clk) begin
        if (reset || clr) begin
            tx_full_flag <= 1'b0;
            tx_half_flag <= 1'b1;
            tx_ready <= 1'b1;
        end else begin
            tx_full_flag <= tx_cnt == FIFO_DEPTH;
            tx_half_flag <= tx_cnt < FIFO_HALF;
            tx_ready <= tx_cnt == 6'h00 && state == S_IDLE;
        end
    end

    // serialiser: data half, null half, then word gap
    assign half_len = ctrl.tx_low_speed ? LS_HALF : HS_HALF;
    assign gap_len = ctrl.tx_low_speed ? LS_GAP : HS_GAP;
    always_ff @(posedge clk) begin
        if (reset || clr) begin
            state <= S_IDLE;
            serial_line_out_a <= 1'b0;
            serial_line_out_b <= 1'b0;
            tx_shift <= 32'h0000_0000;
            lb_word <= 32'h0000_0000;
            lb_valid <= 1'b0;
            bitn <= 5'h00;
            ph <= 9'h000;
        end else begin
            lb_valid <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (transmit_go && tx_cnt != 6'h00)
                        state <= S_LOAD;
                end
                S_LOAD: begin
                    if (tick) begin
                        tx_shift <= {ctrl.parity_insert ?
                            (^tx_mem[tx_rp][30:0]) ^ ~ctrl.parity_sense :
                            tx_mem[tx_rp][31], tx_mem[tx_rp][30:0]};
                        lb_word <= {ctrl.parity_insert ?
                            (^tx_mem[tx_rp][30:0]) ^ ~ctrl.parity_sense :
                            tx_mem[tx_rp][31], tx_mem[tx_rp][30:0]};
                        serial_line_out_a <= tx_mem[tx_rp][0];
                        serial_line_out_b <= ~tx_mem[tx_rp][0];
                        bitn <= 5'h00;
                        ph <= 9'h000;
                        state <= S_DATA;
                    end
                end
                S_DATA: begin
                    if (tick && ph == half_len - 9'h001) begin
                        ph <= 9'h000;
                        serial_line_out_a <= 1'b0;
                        serial_line_out_b <= 1'b0;
                        state <= S_NULL;
                    end else if (tick)
                        ph <= ph + 9'h001;
                end
                S_NULL: begin
                    if (tick && ph == half_len - 9'h001) begin
                        ph <= 9'h000;
                        if (bitn == LAST_BIT) begin
                            lb_valid <= 1'b1;
                            state <= S_GAP;
                        end else begin
                            bitn <= bitn + 5'h01;
                            tx_shift <= {1'b0, tx_shift[31:1]};
                            serial_line_out_a <= tx_shift[1];
                            serial_line_out_b <= ~tx_shift[1];
                            state <= S_DATA;
                        end
                    end else if (tick)
                        ph <= ph + 9'h001;
                end
                S_GAP: begin
                    if (tick && ph == gap_len - 9'h001) begin
                        ph <= 9'h000;
                        state <= S_IDLE;
                    end else if (tick)
                        ph <= ph + 9'h001;
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // checks
    localparam int first_max = FIRST_BIT_CYC;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    full_drop_a: assert property ((ld2 && tx_cnt == FIFO_DEPTH && !tx_pop)
        |=> tx_cnt == FIFO_DEPTH) else $error("load taken when full");
    // chip clear forces the flag high whatever the count was
    half_flag_a: assert property (##1 tx_half_flag == ($past(tx_cnt) <
        FIFO_HALF || $past(clr))) else $error("half flag wrong");
    first_bit_a: assert property ((state == S_IDLE && transmit_go &&
        tx_cnt != 6'h00) |-> ##[1:first_max] state == S_DATA)
        else $error("first bit late");
    null_half_a: assert property (state == S_NULL |->
        !serial_line_out_a && !serial_line_out_b)
        else $error("line not null");
    parity_odd_a: assert property ((tx_pop && ctrl.parity_insert) |=>
        (^tx_shift) == ~$past(ctrl.parity_sense))
        else $error("parity wrong");
    suspend_rx_a: assert property ((ctrl.label_access_mode && !clr) |=>
        rx_cnt == $past(rx_cnt))
        else $error("word stored in label mode");
    filter_drop_a: assert property ((in_valid[0] &&
        ctrl.label_filter_on[0] && !match[0]) |-> !push[0])
        else $error("unmatched word stored");
    ready_low_a: assert property ((tx_cnt != 6'h00 && !clr) |=> !tx_ready)
        else $error("ready high with words held");
    ctrl_keep_a: assert property (clr |=> ctrl == $past(ctrl))
        else $error("clear changed control");
    word_sent_c: cover property (state == S_GAP ##1 state == S_IDLE);
    label_seq_c: cover property (lam_rise ##[1:200] rx[0].wc == LABEL_COUNT);
    overwrite_c: cover property (push[0] && rx_cnt[0] == FIFO_DEPTH);
endmodule

// File: atl_host_model.sv
// Purpose: host side register bus master for the controller
// Assumes: one write and one read at most under way
// Notes: released lines are inverted so stale values never match
`timescale 1ns/1ps
module atl_host_model (
    input wire logic clk,
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    // idle bus from time zero
    initial begin
        {awaddr, awvalid, wdata, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end
    // write: address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awvalid && awready) begin
                awvalid <= 1'b0;
                awaddr <= ~a;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
                wdata <= ~d;
            end
        end while (!(bvalid && bready));
        r = bresp;
        bready <= 1'b0;
    endtask
    // read: address held until taken, data taken with rvalid
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arvalid && arready) begin
                arvalid <= 1'b0;
                araddr <= ~a;
            end
        end while (!(rvalid && rready));
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
endmodule

// File: testbench.sv
// Purpose: self-checking bench for the transmit/label controller
// Assumes: host model on the register bus, bench feeds receivers
// Notes: expected words come from queues and integer arithmetic
`timescale 1ns/1ps
module testbench;
    import atl_pkg::*;
    logic clk = 0;
    logic reset = 1;
    logic transmit_go = 0;
    logic [1:0][31:0] rx_word = '0;
    logic [1:0] rx_valid = '0;
    logic [7:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid;
    logic arready, rvalid, rready, line_a, line_b, full, half, ready;
    logic [31:0] wdata, rdata, d, sh, exp_w;
    logic [1:0] bresp, rresp, r;
    logic [7:0] lab [16];
    logic [31:0] capq [$];
    logic [31:0] rx1q [$];
    int fail_count = 0, tests_run = 0, cyc = 0, nb = 0, hl = 0, w, seed = 56;
    always #10 clk = ~clk;
    atl_tx_label_control dut (.clk(clk), .reset(reset),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .transmit_go(transmit_go), .rx_word(rx_word),
        .rx_valid(rx_valid), .serial_line_out_a(line_a),
        .serial_line_out_b(line_b), .tx_full_flag(full),
        .tx_half_flag(half), .tx_ready(ready));
    atl_host_model host (.clk(clk), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready));
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        tests_run++;
        if (e !== g) begin
            $display("BAD %s expected %h seen %h", n, e, g);
            fail_count++;
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic load(input logic [31:0] v);
        host.wr(TXLO_ADDR, {16'h0000, v[15:0]}, r);
        host.wr(TXHI_ADDR, {16'h0000, v[31:16]}, r);
    endtask
    task automatic feed(input logic [31:0] v);
        @(posedge clk);
        rx_word <= {v, v};
        rx_valid <= 2'b11;
        @(posedge clk);
        rx_valid <= 2'b00;
        rx_word <= {~v, ~v};
    endtask
    // word read as two halves, either half first
    task automatic rdw(input logic [7:0] a, input bit hf,
                       output logic [31:0] v);
        logic [31:0] x;
        host.rd(hf ? a + 8'h04 : a, x, r);
        host.rd(hf ? a : a + 8'h04, v, r);
        v = hf ? {x[15:0], v[15:0]} : {v[15:0], x[15:0]};
    endtask
    // hang guard and serial line monitor, lsb of the word first
    always @(posedge clk) begin
        cyc++;
        if (cyc == 95000) begin
            fail_count++;
            results;
        end
        if (line_a || line_b) begin
            if (hl == 0) begin
                sh = {line_a, sh[31:1]};
                nb++;
            end
            hl++;
        end else if (hl != 0) begin
            chk("bit_high", 250, hl);
            hl = 0;
            if (nb == 32) begin
                capq.push_back(sh);
                nb = 0;
            end
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        reset <= 0;
        host.rd(CTRL_ADDR, d, r);
        chk("ctrl", 32'h0000_0012, d);
        host.rd(STATUS_ADDR, d, r);
        chk("status", 32'h0000_0006, d);
        host.wr(8'h24, 32'h0000_0000, r);
        chk("bad_wr", RESP_SLVERR, r);
        host.rd(8'h28, d, r);
        chk("bad_rd", RESP_SLVERR, r);
        $display("test defaults done");
        // odd parity, even parity, parity off, all in loopback
        for (int m = 0; m < 3; m++) begin
            d = $random(seed);
            host.wr(CTRL_ADDR, (32'(m == 1) << 5) | (32'(m != 2) << 1), r);
            exp_w = (m == 2) ? d : {(^d[30:0]) ^ (m == 0), d[30:0]};
            load(d);
            @(posedge clk);
            chk("ready_low", 0, ready);
            transmit_go <= 1;
            w = 0;
            while (!(line_a || line_b) && w < 300) begin
                @(posedge clk);
                w++;
            end
            chk("first_bit", 1, w <= 125);
            while (capq.size() == 0 && w < 20000) begin
                @(posedge clk);
                w++;
            end
            chk("tx_word", exp_w, capq.pop_front());
            while (ready !== 1'b1 && w < 25000) begin
                @(posedge clk);
                w++;
            end
            chk("ready_high", 1, ready);
            transmit_go <= 0;
            rdw(RX1LO_ADDR, 0, d);
            chk("loop_rx1", exp_w, d);
            rdw(RX2LO_ADDR, 1, d);
            chk("loop_rx2", ~exp_w, d);
        end
        $display("test transmit done");
        host.wr(CTRL_ADDR, 32'h0000_0032, r);
        for (int i = 1; i <= 33; i++) begin
            load($random(seed));
            repeat (2) @(posedge clk);
            chk("half", i < 16, half);
            chk("full", i >= 32, full);
        end
        host.rd(STATUS_ADDR, d, r);
        chk("tx_count", 32, d[9:4]);
        host.wr(CLEAR_ADDR, 32'h0000_0000, r);
        repeat (2) @(posedge clk);
        chk("clr_flags", 3'b110, {ready, half, full});
        host.rd(CTRL_ADDR, d, r);
        chk("clr_ctrl", 32'h0000_0032, d);
        $display("test fifo done");
        host.wr(CTRL_ADDR, 32'h0000_0013, r);
        for (int i = 0; i < 16; i++) begin
            lab[i] = 8'(i * 17);
            host.wr(TXLO_ADDR, {24'h00_0000, lab[i]}, r);
        end
        feed(32'h0000_0000);
        host.wr(CTRL_ADDR, 32'h0000_0012, r);
        host.wr(CTRL_ADDR, 32'h0000_0013, r);
        for (int i = 0; i < 16; i++) begin
            host.rd(RX1HI_ADDR, d, r);
            chk("label", lab[i], d[7:0]);
        end
        host.wr(CTRL_ADDR, 32'h0000_0056, r);
        for (int i = 0; i < 3; i++) begin
            d = $random(seed);
            d[7:0] = (i == 1) ? 8'h5a : lab[i * 3];
            if (i != 1)
                rx1q.push_back(d);
            feed(d);
        end
        host.rd(STATUS_ADDR, d, r);
        chk("rx_counts", {6'h03, 6'h02}, d[21:10]);
        while (rx1q.size() > 0) begin
            rdw(RX1LO_ADDR, 0, d);
            chk("rx1_word", rx1q.pop_front(), d);
        end
        $display("test labels done");
        // repeater: rx1 word read low half first lands in tx fifo
        host.wr(CTRL_ADDR, 32'h0000_0112, r);
        exp_w = $random(seed);
        feed(exp_w);
        rdw(RX1LO_ADDR, 0, d);
        chk("rpt_rx1", exp_w, d);
        host.rd(STATUS_ADDR, d, r);
        chk("rpt_load", 1, d[9:4]);
        transmit_go <= 1;
        while (capq.size() == 0)
            @(posedge clk);
        transmit_go <= 0;
        chk("rpt_tx", {~^exp_w[30:0], exp_w[30:0]}, capq.pop_front());
        $display("test repeater done");
        results;
    end
endmodule
